// ==== src/scw_ctrl_words.sv ====
// control-word decoder for words 01b, 10b and 11b with an Avalon-MM register port
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module scw_ctrl_words (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic [4:0]   i_address,
  input  wire logic         i_read,
  input  wire logic         i_write,
  input  wire logic [31:0]  i_writedata,
  input  wire logic [3:0]   i_byteenable,
  output logic      [31:0]  o_readdata,
  output logic              o_waitrequest,
  input  wire logic         i_link_clk,
  input  wire logic         i_link_data,
  input  wire logic         i_link_latch,
  output logic              o_if_detector_polarity,
  output logic              o_rf_synth_enable,
  output logic              o_if_synth_enable,
  output logic              o_power_down,
  output logic      [16:0]  o_if_main_divider,
  output logic      [7:0]   o_rf_fraction_numerator,
  output logic      [11:0]  o_rf_main_divider,
  output logic              o_rf_prescaler_select,
  output logic              o_if_word_valid,
  output logic              o_rf_word_valid
);
  import scw_pkg::*;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  scw_word_if rx_if ();

  // ---- bus slave state
  scw_bus_state_t     state_q, state_d;
  logic               wait_q, wait_d;
  logic [31:0]        rdata_q, rdata_d;
  logic               link_en_q, link_en_d;
  logic               req;
  logic               addr_ok;
  logic [2:0]         idx;
  logic               bus_wr;

  // ---- decoded fields
  logic               pol_q, pol_d;
  logic [1:0]         en_q, en_d;
  logic [16:0]        ifn_q, ifn_d;
  logic [7:0]         frac_q, frac_d;
  logic [11:0]        rfn_raw_q, rfn_raw_d;
  logic               presc_q, presc_d;
  logic               if_valid_q, if_valid_d;
  logic               rf_valid_q, rf_valid_d;
  logic               presc_ok_q, presc_ok_d;

  // ---- registered outputs
  logic               rf_en_q, rf_en_d;
  logic               if_en_q, if_en_d;
  logic               pd_q, pd_d;
  logic [11:0]        rfn_eff_q, rfn_eff_d;
  logic               pol_out_q, pol_out_d;

  // ---- word load path
  logic               load;
  logic [WORD_W-1:0]  load_word;

  scw_serial_rx u_rx (
    .i_clk         (i_clk),
    .i_arst_n      (i_arst_n),
    .i_link_clk    (i_link_clk),
    .i_link_data   (i_link_data),
    .i_link_latch  (i_link_latch),
    .i_link_enable (link_en_q),
    .word_if       (rx_if)
  );

  assign req     = i_read | i_write;
  assign idx     = i_address[4:2];
  assign addr_ok = (i_address[1:0] == BYTE_OFS_OK);
  assign bus_wr  = i_write && (state_q == BUS_ACK) && addr_ok && (i_byteenable == BE_ALL);

  // ---- bus handshake: waitrequest drops one cycle after the request
  always_comb begin
    state_d   = BUS_IDLE;
    rdata_d   = rdata_q;
    link_en_d = link_en_q;
    if (req && state_q == BUS_IDLE) begin
      state_d = BUS_ACK;
      rdata_d = 32'h0;
      if (i_read && addr_ok) begin
        unique case (idx)
          IDX_STATUS: begin
            rdata_d[STS_IF_VALID] = if_valid_q;
            rdata_d[STS_RF_VALID] = rf_valid_q;
            rdata_d[STS_PRESC_OK] = presc_ok_q;
            rdata_d[STS_PRESC]    = presc_q;
            rdata_d[STS_PD]       = pd_q;
            rdata_d[STS_RF_EN]    = rf_en_q;
            rdata_d[STS_IF_EN]    = if_en_q;
          end
          IDX_CTRL: begin
            rdata_d[CTRL_LINK_EN] = link_en_q;
          end
          default: begin
            rdata_d = 32'h0;
          end
        endcase
      end
    end
    if (bus_wr && idx == IDX_CTRL) begin
      link_en_d = i_writedata[CTRL_LINK_EN];
    end
    wait_d = (state_d != BUS_ACK);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q   <= BUS_IDLE;
      wait_q    <= 1'b1;
      rdata_q   <= 32'h0;
      link_en_q <= LINK_EN_RST;
    end else begin
      state_q   <= state_d;
      wait_q    <= wait_d;
      rdata_q   <= rdata_d;
      link_en_q <= link_en_d;
    end
  end

  // ---- word source: a serial word wins over a bus write in the same cycle
  always_comb begin
    load      = 1'b0;
    load_word = '0;
    if (rx_if.valid) begin
      load      = 1'b1;
      load_word = rx_if.word;
    end else if (bus_wr && (idx == IDX_PRESC || idx == IDX_IF || idx == IDX_RF)) begin
      load      = 1'b1;
      load_word = {i_writedata[WORD_W-1:ADDR_HI+1], idx[ADDR_HI:ADDR_LO]};
    end
  end

  // ---- field decode by the word's own address code
  always_comb begin
    pol_d      = pol_q;
    en_d       = en_q;
    ifn_d      = ifn_q;
    frac_d     = frac_q;
    rfn_raw_d  = rfn_raw_q;
    presc_d    = presc_q;
    if_valid_d = if_valid_q;
    rf_valid_d = rf_valid_q;
    presc_ok_d = presc_ok_q;
    if (load) begin
      unique case (load_word[ADDR_HI:ADDR_LO])
        CODE_PRESC: begin
          presc_d    = load_word[PRESC_BIT];
          presc_ok_d = 1'b1;
        end
        CODE_IF: begin
          pol_d      = load_word[IF_POL_BIT];
          en_d       = load_word[EN_HI:EN_LO];
          ifn_d      = load_word[IFN_HI:IFN_LO];
          if_valid_d = 1'b1;
        end
        CODE_RF: begin
          frac_d     = load_word[FRAC_HI:FRAC_LO];
          rfn_raw_d  = load_word[RFN_HI:RFN_LO];
          rf_valid_d = 1'b1;
        end
        default: begin
          presc_ok_d = presc_ok_q;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pol_q      <= 1'b0;
      en_q       <= EN_BOTH;
      ifn_q      <= 17'h0;
      frac_q     <= 8'h0;
      rfn_raw_q  <= 12'h0;
      presc_q    <= 1'b0;
      if_valid_q <= 1'b0;
      rf_valid_q <= 1'b0;
      presc_ok_q <= 1'b0;
    end else begin
      pol_q      <= pol_d;
      en_q       <= en_d;
      ifn_q      <= ifn_d;
      frac_q     <= frac_d;
      rfn_raw_q  <= rfn_raw_d;
      presc_q    <= presc_d;
      if_valid_q <= if_valid_d;
      rf_valid_q <= rf_valid_d;
      presc_ok_q <= presc_ok_d;
    end
  end

  // ---- derived controls; unwritten words leave everything inactive
  always_comb begin
    rf_en_d   = 1'b0;
    if_en_d   = 1'b0;
    pd_d      = 1'b0;
    pol_out_d = 1'b0;
    rfn_eff_d = 12'h0;
    if (if_valid_q) begin
      pol_out_d = pol_q;
      unique case (en_q)
        EN_BOTH: begin
          rf_en_d = 1'b1;
          if_en_d = 1'b1;
        end
        EN_RF_ONLY: begin
          rf_en_d = 1'b1;
        end
        EN_IF_ONLY: begin
          if_en_d = 1'b1;
        end
        EN_POWER_DOWN: begin
          pd_d = 1'b1;
        end
      endcase
    end
    if (rf_valid_q) begin
      if (presc_q) begin
        rfn_eff_d = rfn_raw_q;
      end else begin
        rfn_eff_d = {1'b0, rfn_raw_q[RFN_NARROW_HI:0]};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rf_en_q   <= 1'b0;
      if_en_q   <= 1'b0;
      pd_q      <= 1'b0;
      pol_out_q <= 1'b0;
      rfn_eff_q <= 12'h0;
    end else begin
      rf_en_q   <= rf_en_d;
      if_en_q   <= if_en_d;
      pd_q      <= pd_d;
      pol_out_q <= pol_out_d;
      rfn_eff_q <= rfn_eff_d;
    end
  end

  assign o_readdata              = rdata_q;
  assign o_waitrequest           = wait_q;
  assign o_if_detector_polarity  = pol_out_q;
  assign o_rf_synth_enable       = rf_en_q;
  assign o_if_synth_enable       = if_en_q;
  assign o_power_down            = pd_q;
  assign o_if_main_divider       = ifn_q;
  assign o_rf_fraction_numerator = frac_q;
  assign o_rf_main_divider       = rfn_eff_q;
  assign o_rf_prescaler_select   = presc_q;
  assign o_if_word_valid         = if_valid_q;
  assign o_rf_word_valid         = rf_valid_q;

  // ---- assertions
  a_if_polarity_take: assert property (
    (load && load_word[ADDR_HI:ADDR_LO] == CODE_IF) |=> pol_q == $past(load_word[IF_POL_BIT]))
    else $error("polarity not taken from if_control_word bit 2");

  a_polarity_output: assert property (
    (if_valid_q && pol_q) |=> o_if_detector_polarity)
    else $error("positive gain polarity not driven");

  a_enable_field: assert property (
    (load && load_word[ADDR_HI:ADDR_LO] == CODE_IF) |=> en_q == $past(load_word[EN_HI:EN_LO]))
    else $error("enable field not taken from bits 4:3");

  a_both_enabled: assert property (
    (if_valid_q && en_q == EN_BOTH) |=> (o_rf_synth_enable && o_if_synth_enable && !o_power_down))
    else $error("field 00 must enable both synthesizers");

  a_rf_only: assert property (
    (if_valid_q && en_q == EN_RF_ONLY) |=> (o_rf_synth_enable && !o_if_synth_enable))
    else $error("field 01 must enable only RF");

  a_if_only: assert property (
    (if_valid_q && en_q == EN_IF_ONLY) |=> (!o_rf_synth_enable && o_if_synth_enable))
    else $error("field 10 must enable only IF");

  a_power_down: assert property ((if_valid_q && en_q == EN_POWER_DOWN) |=>
    (o_power_down && !o_rf_synth_enable && !o_if_synth_enable))
    else $error("field 11 must power down both");

  a_if_divider: assert property ((load && load_word[ADDR_HI:ADDR_LO] == CODE_IF) |=>
    o_if_main_divider == $past(load_word[IFN_HI:IFN_LO]))
    else $error("IF divider not taken from bits 21:5");

  a_rf_route: assert property (
    (load && load_word[ADDR_HI:ADDR_LO] == CODE_RF) |=> (o_rf_word_valid && $stable(ifn_q)))
    else $error("rf_divider_word not routed to RF settings");

  a_rf_fraction: assert property ((load && load_word[ADDR_HI:ADDR_LO] == CODE_RF) |=>
    o_rf_fraction_numerator == $past(load_word[FRAC_HI:FRAC_LO]))
    else $error("RF numerator not taken from bits 9:2");

  a_divider_wide: assert property (
    (rf_valid_q && presc_q) |=> o_rf_main_divider == $past(rfn_raw_q))
    else $error("16/17 divider must use all 12 bits");

  a_divider_narrow: assert property ((rf_valid_q && !presc_q) |=>
    (!o_rf_main_divider[RFN_HI-RFN_LO] && o_rf_main_divider[RFN_NARROW_HI:0] ==
    $past(rfn_raw_q[RFN_NARROW_HI:0]))) else $error("8/9 divider must be 11 bits");

  a_prescaler_take: assert property (
    (load && load_word[ADDR_HI:ADDR_LO] == CODE_PRESC) |=> o_rf_prescaler_select ==
    $past(load_word[PRESC_BIT])) else $error("prescaler not taken from word 01b bit 5");

  a_fields_isolated: assert property (
    (load && load_word[ADDR_HI:ADDR_LO] == CODE_IF) |=> ($stable(frac_q) &&
    $stable(rfn_raw_q) && $stable(presc_q))) else $error("if_control_word disturbed other fields");

  a_unwritten_quiet: assert property (
    !if_valid_q |=> (!o_rf_synth_enable && !o_if_synth_enable && !o_power_down))
    else $error("enables driven before if_control_word written");

  a_bus_answer: assert property (
    (req && state_q == BUS_IDLE) |=> !o_waitrequest ##1 o_waitrequest)
    else $error("bus answer not one cycle wide");

  c_if_word_load: cover property (load && load_word[ADDR_HI:ADDR_LO] == CODE_IF);
  c_rf_word_load: cover property (load && load_word[ADDR_HI:ADDR_LO] == CODE_RF);
  c_serial_word:  cover property (rx_if.valid);
  c_power_down:   cover property (o_power_down);

endmodule
`default_nettype wire

// ==== src/scw_pkg.sv ====
// constants and types for the synthesizer control-word decoder
// Functional notes
// - a loaded word with address code 10b supplies IF detector polarity from bit 2.
// - polarity 0 selects negative oscillator gain, 1 selects positive gain.
// - if_control_word bits 4:3 form the two-bit synthesizer enable field.
// - enable field 00 keeps both RF and IF synthesizers enabled.
// - enable field 01 enables only the RF synthesizer.
// - enable field 10 enables only the IF synthesizer.
// - enable field 11 powers down both synthesizers.
// - if_control_word bits 21:5 give the 17-bit IF main divider.
// - a word with address code 11b goes to the RF fraction and divider.
// - rf_divider_word bits 9:2 give the RF fractional numerator, modulo up to 256.
// - rf_divider_word bits 21:10 give the RF main divider, 12 bits with 16/17.
// - with the 8/9 prescaler the RF main divider is an 11-bit ratio.
// - prescaler choice is bit 5 of word 01b: 0 is 8/9, 1 is 16/17.
package scw_pkg;

  localparam int          WORD_W        = 22;
  localparam logic [4:0]  BIT_CNT_FULL  = 5'h16;

  localparam int          ADDR_HI       = 1;
  localparam int          ADDR_LO       = 0;
  localparam logic [1:0]  CODE_PRESC    = 2'h1;
  localparam logic [1:0]  CODE_IF       = 2'h2;
  localparam logic [1:0]  CODE_RF       = 2'h3;

  localparam int          IF_POL_BIT    = 2;
  localparam int          EN_HI         = 4;
  localparam int          EN_LO         = 3;
  localparam int          IFN_HI        = 21;
  localparam int          IFN_LO        = 5;
  localparam int          FRAC_HI       = 9;
  localparam int          FRAC_LO       = 2;
  localparam int          RFN_HI        = 21;
  localparam int          RFN_LO        = 10;
  localparam int          RFN_NARROW_HI = 10;
  localparam int          PRESC_BIT     = 5;

  localparam logic [1:0]  EN_BOTH       = 2'h0;
  localparam logic [1:0]  EN_RF_ONLY    = 2'h1;
  localparam logic [1:0]  EN_IF_ONLY    = 2'h2;
  localparam logic [1:0]  EN_POWER_DOWN = 2'h3;

  localparam logic [2:0]  IDX_PRESC     = 3'h1;
  localparam logic [2:0]  IDX_IF        = 3'h2;
  localparam logic [2:0]  IDX_RF        = 3'h3;
  localparam logic [2:0]  IDX_STATUS    = 3'h4;
  localparam logic [2:0]  IDX_CTRL      = 3'h5;
  localparam logic [1:0]  BYTE_OFS_OK   = 2'h0;
  localparam logic [3:0]  BE_ALL        = 4'hF;

  localparam int          STS_IF_VALID  = 0;
  localparam int          STS_RF_VALID  = 1;
  localparam int          STS_PRESC_OK  = 2;
  localparam int          STS_PRESC     = 3;
  localparam int          STS_PD        = 4;
  localparam int          STS_RF_EN     = 5;
  localparam int          STS_IF_EN     = 6;
  localparam int          CTRL_LINK_EN  = 0;
  localparam logic        LINK_EN_RST   = 1'h1;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } scw_bus_state_t;

endpackage

// ==== src/scw_word_if.sv ====
// carrier for one received control word between link receiver and decoder
`timescale 1ns/1ps
`default_nettype none
interface scw_word_if;
  logic                        valid;
  logic [scw_pkg::WORD_W-1:0]  word;
  modport src (output valid, output word);
  modport dst (input valid, input word);
endinterface
`default_nettype wire

// ==== src/scw_serial_rx.sv ====
// three-wire link receiver: synchronises pins, shifts bits, emits latched words
`timescale 1ns/1ps
`default_nettype none
module scw_serial_rx (
  input  wire logic  i_clk,
  input  wire logic  i_arst_n,
  input  wire logic  i_link_clk,
  input  wire logic  i_link_data,
  input  wire logic  i_link_latch,
  input  wire logic  i_link_enable,
  scw_word_if.src    word_if
);
  import scw_pkg::*;

  logic [2:0]         clk_s_q;
  logic [2:0]         le_s_q;
  logic [1:0]         dat_s_q;
  logic [WORD_W-1:0]  shift_q, shift_d;
  logic [4:0]         cnt_q, cnt_d;
  logic               valid_q, valid_d;
  logic [WORD_W-1:0]  word_q, word_d;
  logic               clk_rise;
  logic               le_rise;

  // two-flop synchronisers plus one edge-history stage
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_s_q <= 3'h0;
      le_s_q  <= 3'h0;
      dat_s_q <= 2'h0;
    end else begin
      clk_s_q <= {clk_s_q[1:0], i_link_clk};
      le_s_q  <= {le_s_q[1:0], i_link_latch};
      dat_s_q <= {dat_s_q[0], i_link_data};
    end
  end

  assign clk_rise = clk_s_q[1] & ~clk_s_q[2];
  assign le_rise  = le_s_q[1] & ~le_s_q[2];

  always_comb begin
    shift_d = shift_q;
    cnt_d   = cnt_q;
    valid_d = 1'b0;
    word_d  = word_q;
    if (clk_rise) begin
      shift_d = {shift_q[WORD_W-2:0], dat_s_q[1]};
      if (cnt_q != BIT_CNT_FULL) begin
        cnt_d = cnt_q + 5'h1;
      end
    end
    // a latch after a short frame is discarded; the word is one 22-bit unit
    if (le_rise) begin
      cnt_d = 5'h0;
      if (i_link_enable && cnt_q == BIT_CNT_FULL) begin
        valid_d = 1'b1;
        word_d  = shift_q;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_q <= '0;
      cnt_q   <= 5'h0;
      valid_q <= 1'b0;
      word_q  <= '0;
    end else begin
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      valid_q <= valid_d;
      word_q  <= word_d;
    end
  end

  assign word_if.valid = valid_q;
  assign word_if.word  = word_q;

  a_short_frame_drop: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (le_rise && cnt_q != BIT_CNT_FULL) |=> !valid_q)
    else $error("word emitted after a short frame");

endmodule
`default_nettype wire

// ==== testbench/scw_host_model.sv ====
// host model that loads control words over the three-wire serial link
`timescale 1ns/1ps
`default_nettype none
module scw_host_model (
  input  wire logic  i_clk,
  output logic       o_link_clk,
  output logic       o_link_data,
  output logic       o_link_latch
);
  localparam int HALF = 4;

  initial begin
    o_link_clk   = 1'b0;
    o_link_data  = 1'b0;
    o_link_latch = 1'b0;
  end

  // shifts the n lowest bits msb first; link clock idles low between frames
  task automatic send_frame(input logic [21:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      o_link_clk  <= 1'b0;
      o_link_data <= w[i];
      repeat (HALF) @(posedge i_clk);
      o_link_clk <= 1'b1;
      repeat (HALF) @(posedge i_clk);
    end
    o_link_clk  <= 1'b0;
    o_link_data <= ~o_link_data;
    repeat (HALF) @(posedge i_clk);
    o_link_latch <= 1'b1;
    repeat (HALF) @(posedge i_clk);
    o_link_latch <= 1'b0;
    repeat (12) @(posedge i_clk);
  endtask

  // power-up word: dithered fractional mode, chosen prescaler
  task automatic load_prescaler(input logic presc);
    send_frame({2'b10, 14'h0, presc, 3'h0, 2'b01}, 22);
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the control-word decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb;
  import scw_pkg::*;
  typedef struct packed { logic [1:0] code; logic presc; logic [21:0] word; } scw_row_t;
  logic        i_clk, i_arst_n, i_read, i_write, lclk, ldata, llatch;
  logic [4:0]  i_address;
  logic [31:0] i_writedata, o_readdata, rd;
  logic [3:0]  i_byteenable;
  logic        o_waitrequest, o_if_detector_polarity, o_rf_synth_enable, o_if_synth_enable;
  logic        o_power_down, o_rf_prescaler_select, o_if_word_valid, o_rf_word_valid;
  logic [16:0] o_if_main_divider, last_if;
  logic [7:0]  o_rf_fraction_numerator;
  logic [11:0] o_rf_main_divider;
  int          n_mismatch = 0;
  int          checked = 0;
  localparam scw_row_t SER_IF = '{CODE_IF, 1'b1, 22'h2AAAB6};
  localparam scw_row_t SER_RF = '{CODE_RF, 1'b1, 22'h3FFFFF};
  scw_row_t rows [8] = '{
    '{CODE_IF, 1'b0, 22'h3FFFE0}, '{CODE_IF, 1'b0, 22'h00002C},
    '{CODE_IF, 1'b0, 22'h2AAAB4}, '{CODE_IF, 1'b0, 22'h155558},
    '{CODE_RF, 1'b1, 22'h3FFFFC}, '{CODE_RF, 1'b0, 22'h3FFFFC},
    '{CODE_RF, 1'b1, 22'h200400}, '{CODE_RF, 1'b0, 22'h200400}};

  scw_ctrl_words DUT (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_link_clk(lclk),
    .i_link_data(ldata), .i_link_latch(llatch),
    .o_if_detector_polarity(o_if_detector_polarity), .o_rf_synth_enable(o_rf_synth_enable),
    .o_if_synth_enable(o_if_synth_enable), .o_power_down(o_power_down),
    .o_if_main_divider(o_if_main_divider), .o_rf_fraction_numerator(o_rf_fraction_numerator),
    .o_rf_main_divider(o_rf_main_divider), .o_rf_prescaler_select(o_rf_prescaler_select),
    .o_if_word_valid(o_if_word_valid), .o_rf_word_valid(o_rf_word_valid));

  scw_host_model host (.i_clk(i_clk), .o_link_clk(lclk), .o_link_data(ldata),
    .o_link_latch(llatch));

  always #10 i_clk = ~i_clk;

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // holds the request until waitrequest is sampled low at a rising edge
  task automatic wait_ack;
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    `CHK("waitrequest", 1'b0, o_waitrequest)
  endtask

  task automatic bus_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge i_clk);
    i_address    <= a;
    i_writedata  <= d;
    i_byteenable <= be;
    i_write      <= 1'b1;
    wait_ack();
    i_write <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask

  task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_address <= a;
    i_read    <= 1'b1;
    wait_ack();
    d = o_readdata;
    i_read <= 1'b0;
  endtask

  task automatic check_row(input scw_row_t r);
    logic [1:0] en;
    logic [11:0] rfd;
    en = r.word[4:3];
    rfd = r.presc ? r.word[21:10] : {1'b0, r.word[20:10]};
    if (r.code == CODE_IF) begin
      last_if = r.word[21:5];
      `CHK("polarity", r.word[2], o_if_detector_polarity)
      `CHK("rf_en", (en == EN_BOTH) || (en == EN_RF_ONLY), o_rf_synth_enable)
      `CHK("if_en", (en == EN_BOTH) || (en == EN_IF_ONLY), o_if_synth_enable)
      `CHK("pd", en == EN_POWER_DOWN, o_power_down)
      `CHK("if_div", r.word[21:5], o_if_main_divider)
      `CHK("if_valid", 1'b1, o_if_word_valid)
    end else begin
      `CHK("rf_frac", r.word[9:2], o_rf_fraction_numerator)
      `CHK("rf_div", rfd, o_rf_main_divider)
      `CHK("presc", r.presc, o_rf_prescaler_select)
      `CHK("if_kept", last_if, o_if_main_divider)
      `CHK("rf_valid", 1'b1, o_rf_word_valid)
    end
  endtask

  task automatic check_idle;
    `CHK("wait_idle", 1'b1, o_waitrequest)
    `CHK("valids", 2'b00, {o_if_word_valid, o_rf_word_valid})
    `CHK("pol_idle", 1'b0, o_if_detector_polarity)
    `CHK("en_idle", 3'b000, {o_rf_synth_enable, o_if_synth_enable, o_power_down})
    `CHK("div_idle", 12'h000, o_rf_main_divider)
    `CHK("if_div_idle", 17'h00000, o_if_main_divider)
    `CHK("frac_presc_idle", 9'h000, {o_rf_fraction_numerator, o_rf_prescaler_select})
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    i_clk = 1'b0;
    i_arst_n = 1'b0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = 5'h00;
    i_writedata = 32'h0;
    i_byteenable = 4'h0;
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    check_idle();
    foreach (rows[k]) begin
      bus_write(5'h04, {10'h0, 2'b10, 14'h0, rows[k].presc, 5'h01}, BE_ALL);
      bus_write({1'b0, rows[k].code, 2'b00}, {10'h0, rows[k].word}, BE_ALL);
      check_row(rows[k]);
    end
    bus_read(5'h10, rd);
    `CHK("status", 32'h00000017, rd)
    bus_read(5'h08, rd);
    `CHK("wo_read", 32'h0, rd)
    bus_read(5'h1C, rd);
    `CHK("unmapped", 32'h0, rd)
    bus_read(5'h14, rd);
    `CHK("ctrl_rst", 32'h1, rd)
    bus_write(5'h0C, 32'h0, 4'h7);
    bus_write(5'h0E, 32'h0, BE_ALL);
    check_row(rows[7]);
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    check_idle();
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    check_idle();
    host.load_prescaler(1'b1);
    host.send_frame(SER_IF.word, 22);
    check_row(SER_IF);
    host.send_frame(SER_RF.word, 22);
    check_row(SER_RF);
    host.send_frame(22'h3FFFE0, 22);
    check_row(SER_IF);
    host.send_frame(22'h000003, 10);
    check_row(SER_RF);
    bus_write(5'h14, 32'h0, BE_ALL);
    host.send_frame(22'h00002E, 22);
    check_row(SER_IF);
    complete_run();
  end
endmodule
`default_nettype wire
